// *** hic_pkg.sv ***
// constants and types shared by the hub controller interrupt block
package hic_pkg;

    // ------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_GIE  = 10'h020; // global irq enable
    localparam logic [9:0] IDX_EPE  = 10'h021; // endpoint irq enable
    localparam logic [9:0] IDX_PSC  = 10'h0FF; // status and control

    // ------------------------------------------------------------
    // field layouts and values after reset
    // ------------------------------------------------------------
    localparam logic [7:0] GIE_MASK  = 8'h6F; // bits 4 and 7 reserved
    localparam logic [7:0] EPE_MASK  = 8'h1F; // bits 7..5 reserved
    localparam logic [7:0] PSC_WMASK = 8'h7B; // bits 2 and 7 read only
    localparam logic [7:0] PSC_RST   = 8'h11; // run and power-on set
    localparam int         PSC_IE    = 2;     // global enable sense
    localparam int         PSC_BRST  = 5;     // bus reset seen
    localparam int         PSC_PEND  = 7;     // irq pending
    localparam int         NSRC      = 12;    // interrupt sources
    localparam logic [13:0] PC_RESET = 14'h0000; // start after reset
    localparam logic [13:0] VEC_STEP = 14'h0002; // two-byte slots
    localparam logic [1:0] RESP_OK   = 2'h0;  // axi okay
    localparam logic [1:0] RESP_ERR  = 2'h2;  // axi slave error

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ    = 10;    // aclk rate
    localparam int SE0_MIN_NS = 12000; // shortest reset recognised
    localparam int SE0_MAX_NS = 16000; // longest before it must be
    localparam int SE0_CYC    = (SE0_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int CALL_CYC   = 10;    // forced call length
    localparam int JMP_CYC    = 5;     // jump at the vector

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,   // waiting for an instruction boundary
        ST_CALL = 2'b10    // forced call under way
    } hic_st_t;

    // one-cycle source events
    typedef struct packed {
        logic       i2c;   // serial bus event
        logic       gpio;  // port pin event
        logic       conv;  // converter event
        logic       hub;   // repeater status change
        logic [4:0] ep;    // endpoint a0,a1,a2,b0,b1 acknowledge
        logic       t1ms;  // 1.024 ms tick
        logic       t128;  // 128 us tick
    } hic_evt_t;

    // from the processor core
    typedef struct packed {
        logic        instr_done;             // instruction boundary
        logic        disable_irq_instr;      // clears global enable
        logic        enable_irq_instr;       // sets global enable
        logic        return_from_irq_instr;  // restores and enables
        logic [13:0] pc;                     // address to return to
        logic        carry_flag;             // current carry
        logic        zero_flag;              // current zero
        logic [15:0] pop_word;               // stack word on return
    } hic_core_in_t;

    // to the processor core
    typedef struct packed {
        logic        take;        // one-cycle call start
        logic        busy;        // call in progress, core stalls
        logic [13:0] vector;      // call target
        logic [15:0] push_word;   // {carry, zero, pc}
        logic        carry_flag;  // restored carry
        logic        zero_flag;   // restored zero
        logic        gie;         // global enable level
    } hic_core_out_t;

    // whole block state
    typedef struct packed {
        hic_st_t     st;
        logic [3:0]  cnt;
        logic        gie;
        logic [7:0]  gien;
        logic [7:0]  epen;
        logic [7:0]  psc;
        logic [11:0] pend;
        logic        take;
        logic [11:0] take_oh;
        logic [13:0] vec;
        logic [15:0] push;
        logic        carry;
        logic        zero;
        logic [7:0]  se0_cnt;
        logic        se0_seen;
        logic        usb_clr;
        logic        aw_got;
        logic        w_got;
        logic [9:0]  awidx;
        logic [7:0]  wdata;
        logic        wlane;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [7:0]  rdata;
    } hic_state_t;

    localparam hic_state_t STATE_RST = '{st: ST_IDLE, psc: PSC_RST, default: '0};

endpackage : hic_pkg

// *** hic_irq_ctrl.sv ***
// interrupt controller with bus reset detect and axi4-lite registers
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// - endpoint enable bits 0-4, upper reserved
// - reset clears both enable registers
// - one pending flop per source, sticky
// - pending requests only when enabled; the converter request is always enabled here
// - lowest-numbered request taken at instruction end
// - clear global enable, pending, then call
// - call pushes pc, carry and zero
// - return restores flags, sets global enable
// - enable/disable instructions touch global enable
// - global enable readable at status bit 2
// - status bit 7 shows pending request
// - lower vector number always wins
// - reset start 0, vectors two bytes
// - endpoints, hub, converter, gpio, i2c vectors
// - call costs ten cycles, jump five
// - both lines low 12 us is reset
// - bus reset sets status bit 5
// - bus reset clears device address registers
// - bus reset clears hub port registers
// - bus reset interrupt at reset end
// - endpoint irq on final acknowledged packet
// - global enable bit layout
// - pending bit cleared by acknowledge
// ------------------------------------------------------------
module hic_irq_ctrl #(
    parameter int ADDR_W = 12   // axi address width
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  ce,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // sources, core and usb side
    input  wire hic_pkg::hic_evt_t     evt,
    input  wire logic                  usb_se0,
    input  wire hic_pkg::hic_core_in_t core_in,
    output hic_pkg::hic_core_out_t     core_out,
    output logic                       usb_regs_clear
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 12)
    begin : g_chk
        $error("hic_irq_ctrl: ADDR_W must be at least 12");
    end

    hic_pkg::hic_state_t s_q;     // registered state
    hic_pkg::hic_state_t s_d;     // next state
    logic [11:0]         en_w;    // per-source enable
    logic [11:0]         req_w;   // enabled pending
    logic [11:0]         set_w;   // set events this cycle
    logic [11:0]         oh_w;    // lowest-numbered request
    logic [13:0]         vec_w;   // its vector address
    logic                brst_end; // se0 gone after reset
    logic [7:0]          psc_rd;  // status as read
    logic                aw_now;  // write address taken
    logic                w_now;   // write data taken
    logic                ar_now;  // read address taken
    logic [9:0]          aridx;   // read word index

    // ------------------------------------------------------------
    // request network
    // ------------------------------------------------------------
    // source order: bus reset, 128us, 1ms, ep a0..b1, hub,
    // converter, gpio, i2c
    always_comb
    begin
        en_w = {s_q.gien[6], s_q.gien[5], 1'b1, s_q.gien[3],
                s_q.epen[4:0], s_q.gien[2:0]};
        req_w = s_q.pend & en_w;
        oh_w  = req_w & (~req_w + 12'h001);
        vec_w = hic_pkg::PC_RESET;
        for (int i = hic_pkg::NSRC - 1; i >= 0; i--)
        begin
            if (oh_w[i])
            begin
                vec_w = 14'(i + 1) * hic_pkg::VEC_STEP;
            end
        end
    end

    // endpoint events come already qualified by acknowledge
    assign brst_end = s_q.se0_seen && !usb_se0;
    assign set_w = {evt.i2c, evt.gpio, evt.conv, evt.hub,
                    evt.ep, evt.t1ms, evt.t128, brst_end};

    // ------------------------------------------------------------
    // status as software sees it
    // ------------------------------------------------------------
    always_comb
    begin
        psc_rd                    = s_q.psc;
        psc_rd[hic_pkg::PSC_IE]   = s_q.gie;
        psc_rd[hic_pkg::PSC_PEND] = |req_w;
    end

    // ------------------------------------------------------------
    // bus handshakes
    // ------------------------------------------------------------
    assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;
    assign aw_now = s_axi_awvalid && s_axi_awready;
    assign w_now  = s_axi_wvalid && s_axi_wready;
    assign ar_now = s_axi_arvalid && s_axi_arready;
    assign aridx  = s_axi_araddr[11:2];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_d         = s_q;
        s_d.take    = 1'b0;
        s_d.usb_clr = 1'b0;

        // write channel capture, either order
        if (aw_now)
        begin
            s_d.aw_got = 1'b1;
            s_d.awidx  = s_axi_awaddr[11:2];
        end
        if (w_now)
        begin
            s_d.w_got = 1'b1;
            s_d.wdata = s_axi_wdata[7:0];
            s_d.wlane = s_axi_wstrb[0];
        end

        // register write once both halves are held
        if (s_q.aw_got && s_q.w_got)
        begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = hic_pkg::RESP_OK;
            unique case (s_q.awidx)
                hic_pkg::IDX_GIE:
                begin
                    if (s_q.wlane)
                    begin
                        s_d.gien = s_q.wdata & hic_pkg::GIE_MASK;
                    end
                end
                hic_pkg::IDX_EPE:
                begin
                    if (s_q.wlane)
                    begin
                        s_d.epen = s_q.wdata & hic_pkg::EPE_MASK;
                    end
                end
                hic_pkg::IDX_PSC:
                begin
                    if (s_q.wlane)
                    begin
                        s_d.psc = (s_q.wdata & hic_pkg::PSC_WMASK)
                                | (s_q.psc & ~hic_pkg::PSC_WMASK);
                    end
                end
                default:
                begin
                    s_d.bresp = hic_pkg::RESP_ERR;  // unmapped
                end
            endcase
        end
        else if (s_q.bvalid && s_axi_bready)
        begin
            s_d.bvalid = 1'b0;
        end

        // read channel
        if (ar_now)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = hic_pkg::RESP_OK;
            unique case (aridx)
                hic_pkg::IDX_GIE: s_d.rdata = s_q.gien;
                hic_pkg::IDX_EPE: s_d.rdata = s_q.epen;
                hic_pkg::IDX_PSC: s_d.rdata = psc_rd;
                default:
                begin
                    s_d.rdata = 8'h00;
                    s_d.rresp = hic_pkg::RESP_ERR;
                end
            endcase
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end

        // upstream single-ended-zero timing
        if (usb_se0)
        begin
            if (s_q.se0_cnt != 8'(hic_pkg::SE0_CYC))
            begin
                s_d.se0_cnt = s_q.se0_cnt + 8'h01;
            end
            if (s_q.se0_cnt == 8'(hic_pkg::SE0_CYC - 1))
            begin
                s_d.se0_seen = 1'b1;
                s_d.usb_clr  = 1'b1;
            end
        end
        else
        begin
            s_d.se0_cnt  = 8'h00;
            s_d.se0_seen = 1'b0;
        end
        if (s_d.usb_clr)
        begin
            s_d.psc[hic_pkg::PSC_BRST] = 1'b1;
        end

        // pending flops: new events set, take clears, set wins
        s_d.pend = s_q.pend | set_w;

        // processor instructions
        if (core_in.disable_irq_instr)
        begin
            s_d.gie = 1'b0;
        end
        if (core_in.enable_irq_instr)
        begin
            s_d.gie = 1'b1;
        end
        if (core_in.return_from_irq_instr)
        begin
            s_d.gie   = 1'b1;
            s_d.carry = core_in.pop_word[15];
            s_d.zero  = core_in.pop_word[14];
        end

        // acknowledge sequencer
        unique case (s_q.st)
            hic_pkg::ST_IDLE:
            begin
                if (core_in.instr_done && s_q.gie && (|req_w)
                    && !core_in.disable_irq_instr)
                begin
                    s_d.gie     = 1'b0;
                    s_d.pend    = (s_q.pend & ~oh_w) | set_w;
                    s_d.take    = 1'b1;
                    s_d.take_oh = oh_w;
                    s_d.vec     = vec_w;
                    s_d.push    = {core_in.carry_flag, core_in.zero_flag,
                                   core_in.pc};
                    s_d.cnt     = 4'(hic_pkg::CALL_CYC - 1);
                    s_d.st      = hic_pkg::ST_CALL;
                end
            end
            hic_pkg::ST_CALL:
            begin
                // core is stalled for the whole forced call
                if (s_q.cnt == 4'h0)
                begin
                    s_d.st = hic_pkg::ST_IDLE;
                end
                else
                begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end
            end
            default:
            begin
                s_d.st = hic_pkg::ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register, clock enable freezes everything
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= hic_pkg::STATE_RST;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_bvalid        = s_q.bvalid;
    assign s_axi_bresp         = s_q.bresp;
    assign s_axi_rvalid        = s_q.rvalid;
    assign s_axi_rresp         = s_q.rresp;
    assign s_axi_rdata         = {24'h000000, s_q.rdata};
    assign core_out.take       = s_q.take;
    assign core_out.busy       = (s_q.st == hic_pkg::ST_CALL);
    assign core_out.vector     = s_q.vec;
    assign core_out.push_word  = s_q.push;
    assign core_out.carry_flag = s_q.carry;
    assign core_out.zero_flag  = s_q.zero;
    assign core_out.gie        = s_q.gie;
    assign usb_regs_clear      = s_q.usb_clr;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // busy cycles of the running call, counted apart from the sequencer
    logic [3:0] busy_len_q; // cycles of the current call so far
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            busy_len_q <= 4'h0;
        end
        else if (ce)
        begin
            busy_len_q <= core_out.busy ? busy_len_q + 4'h1 : 4'h0;
        end
    end

    a_call_length: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && core_out.busy |=> core_out.busy == (busy_len_q < 4'(hic_pkg::CALL_CYC))
    ) else $error("forced call not ten cycles");

    a_take_clears: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(ce) && s_q.take |-> !s_q.gie && core_out.busy
            && ((s_q.take_oh & $past(s_q.pend)) != 12'h000)
    ) else $error("acknowledge did not clear enable");

    a_pend_sticky: assert property (
        @(posedge aclk) disable iff (!aresetn)
        !s_q.take |-> (($past(s_q.pend) & ~s_q.pend) == 12'h000)
    ) else $error("pending flag lost without service");

    a_take_enabled: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $past(ce) && s_q.take |-> (($past(req_w) & s_q.take_oh) != 12'h000)
    ) else $error("disabled source was serviced");

    a_prio_lowest: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_q.take |-> (($past(req_w) & (s_q.take_oh - 12'h001)) == 12'h000)
    ) else $error("lower vector was passed over");

    a_vector_addr: assert property (
        @(posedge aclk) disable iff (!aresetn)
        s_q.take && s_q.take_oh[3] |-> s_q.vec == 14'h0008
    ) else $error("endpoint a0 vector wrong");

    a_brst_record: assert property (
        @(posedge aclk) disable iff (!aresetn)
        $rose(s_q.se0_seen) |-> usb_regs_clear && s_q.psc[5]
            && ($past(s_q.se0_cnt) == 8'(hic_pkg::SE0_CYC - 1))
    ) else $error("bus reset not recorded");

    a_brst_end: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && s_q.se0_seen && !usb_se0 |=> s_q.pend[0] || s_q.take
    ) else $error("bus reset irq not raised at se0 end");

    a_return_from_irq_instr_gie: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ce && core_in.return_from_irq_instr && !core_in.instr_done
            |=> s_q.gie
    ) else $error("return did not enable interrupts");

endmodule : hic_irq_ctrl

// *** hic_core_model.sv ***
// behavioural processor core facing the interrupt controller
`timescale 1ns/10ps
module hic_core_model (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic                   do_ei,
    input  wire logic                   do_di,
    input  wire logic                   do_return_from_irq_instr,
    input  wire hic_pkg::hic_core_out_t core_out,
    output hic_pkg::hic_core_in_t       core_in
);
    // ------------------------------------------------------------
    // instruction stream and one-deep stack
    // ------------------------------------------------------------
    logic [1:0]  phase_q; // four-cycle instruction length
    logic [15:0] stack_q; // word pushed by the forced call

    // core stalls while the forced call runs, else ends an instruction every fourth cycle
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            core_in <= '0;
            phase_q <= 2'h0;
            stack_q <= 16'h0000;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
            core_in.instr_done <= !core_out.busy && phase_q == 2'h3;
            core_in.enable_irq_instr <= do_ei;
            core_in.disable_irq_instr <= do_di;
            core_in.return_from_irq_instr <= do_return_from_irq_instr;
            core_in.carry_flag <= 1'b1;
            core_in.zero_flag <= 1'b0;
            if (core_in.instr_done)
                core_in.pc <= core_in.pc + 14'h0002;
            if (core_out.take)
                stack_q <= core_out.push_word;
            core_in.pop_word <= stack_q;
        end
    end
endmodule : hic_core_model

// *** tb.sv ***
// register, interrupt and bus reset tests of the controller
`timescale 1ns/10ps
module tb;
    logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic                   awready, wready, bvalid, arready, rvalid, usb_se0, usb_regs_clear;
    logic                   do_ei, do_di, do_return_from_irq_instr, ce;
    logic [11:0]            awaddr, araddr;
    logic [31:0]            wdata, rdata;
    logic [1:0]             bresp, rresp;
    hic_pkg::hic_evt_t      evt;  // source pulses
    hic_pkg::hic_core_in_t  core_in;
    hic_pkg::hic_core_out_t core_out;
    hic_pkg::hic_evt_t      e;    // scratch event
    int                     error_cnt, checked, n_take, n_clr, busy_n, takes_exp;
    logic [13:0]            vec_seen;  // vector of last call
    logic [15:0]            push_seen; // word pushed by last call

    hic_irq_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .evt(evt), .usb_se0(usb_se0),
        .core_in(core_in), .core_out(core_out), .usb_regs_clear(usb_regs_clear));
    hic_core_model core_u (.aclk(aclk), .aresetn(aresetn), .do_ei(do_ei), .do_di(do_di),
        .do_return_from_irq_instr(do_return_from_irq_instr), .core_out(core_out), .core_in(core_in));

    // ------------------------------------------------------------
    // clock, watchdog and monitors
    // ------------------------------------------------------------
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    // whole run needs about 400 cycles
    initial
    begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        tally_and_finish();
    end
    // counts calls, busy cycles and clear pulses
    always @(posedge aclk)
    begin
        if (core_out.take)
        begin
            n_take <= n_take + 1;
            vec_seen <= core_out.vector;
            push_seen <= core_out.push_word;
            busy_n <= 1;
        end
        else if (core_out.busy)
            busy_n <= busy_n + 1;
        if (usb_regs_clear)
            n_clr <= n_clr + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x)
        begin
            error_cnt++;
            $display("[FAIL] %0t: got %h expected %h", $time, s, x);
        end
    endtask : check
    // axi write, address and data released each on its own handshake
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ra, rw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        ra = 1'b0;
        rw = 1'b0;
        while (!(ra && rw))
        begin
            @(negedge aclk);
            if (awready && !ra) ra = 1'b1; else if (!ra) ra = 1'b0;
            if (wready && !rw) rw = 1'b1; else if (!rw) rw = 1'b0;
            @(posedge aclk);
            if (ra) awvalid <= 1'b0;
            if (rw) wvalid <= 1'b0;
        end
        do @(negedge aclk); while (!bvalid);
        check({30'h0, bresp}, {30'h0, hic_pkg::RESP_OK});
        @(posedge aclk);
        bready <= 1'b0;
    endtask : wr
    // axi read compared with expected data and response
    task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (!rvalid);
        check(rdata, {24'h0, x});
        check({30'h0, rresp}, {30'h0, r});
        @(posedge aclk);
        rready <= 1'b0;
    endtask : rd
    // one-cycle source events
    task automatic pulse(input hic_pkg::hic_evt_t v);
        @(posedge aclk);
        evt <= v;
        @(posedge aclk);
        evt <= '0;
    endtask : pulse
    // instruction request {ei, di, return_from_irq_instr} to the core
    task automatic ins(input logic [2:0] v);
        @(posedge aclk);
        {do_ei, do_di, do_return_from_irq_instr} <= v;
        @(posedge aclk);
        {do_ei, do_di, do_return_from_irq_instr} <= 3'h0;
    endtask : ins
    // next forced call: vector, ten busy cycles, global enable off
    task automatic taken(input logic [13:0] v);
        takes_exp++;
        for (int i = 0; i < 300 && n_take < takes_exp; i++) @(negedge aclk);
        do @(negedge aclk); while (core_out.busy);
        check({18'h0, vec_seen}, {18'h0, v});
        check(busy_n, 10);
        check({31'h0, core_out.gie}, 32'h0);
    endtask : taken
    task automatic tally_and_finish();
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, usb_se0} = 7'h00;
        {do_ei, do_di, do_return_from_irq_instr, ce} = 4'h1;
        {awaddr, araddr, wdata, evt} = '0;
        {error_cnt, checked, n_take, n_clr, busy_n, takes_exp} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h080, 8'h00, hic_pkg::RESP_OK);
        rd(12'h084, 8'h00, hic_pkg::RESP_OK);
        rd(12'h3FC, 8'h11, hic_pkg::RESP_OK);
        rd(12'h000, 8'h00, hic_pkg::RESP_ERR);
        wr(12'h084, 8'hFF);
        rd(12'h084, 8'h1F, hic_pkg::RESP_OK);
        wr(12'h080, 8'hFF);
        rd(12'h080, 8'h6F, hic_pkg::RESP_OK);
        // pending latched with global enable off, no call
        e = '0;
        e.ep = 5'h04;
        e.i2c = 1'b1;
        pulse(e);
        repeat (12) @(posedge aclk);
        check(n_take, 0);
        rd(12'h3FC, 8'h91, hic_pkg::RESP_OK);
        ins(3'h4);
        taken(14'h000C);
        check({16'h0, push_seen}, {16'h0, 2'b10, core_in.pc - 14'h0002});
        rd(12'h3FC, 8'h91, hic_pkg::RESP_OK);
        ins(3'h1);
        taken(14'h0018);
        check({30'h0, core_out.carry_flag, core_out.zero_flag}, 32'h2);
        ins(3'h1);
        repeat (6) @(posedge aclk);
        rd(12'h3FC, 8'h15, hic_pkg::RESP_OK);
        ins(3'h2);
        repeat (4) @(posedge aclk);
        check({31'h0, core_out.gie}, 32'h0);
        ins(3'h4);
        // two timers at once: the lower vector wins
        e = '0;
        e.t128 = 1'b1;
        e.t1ms = 1'b1;
        pulse(e);
        taken(14'h0004);
        ins(3'h1);
        taken(14'h0006);
        ins(3'h1);
        // bus reset: clear pulse during the low, call after it ends
        usb_se0 <= 1'b1;
        repeat (130) @(posedge aclk);
        check(n_clr, 1);
        rd(12'h3FC, 8'h35, hic_pkg::RESP_OK);
        check(n_take, takes_exp);
        usb_se0 <= 1'b0;
        taken(14'h0002);
        ins(3'h1);
        // disabled endpoint stays latched until enabled
        wr(12'h084, 8'h00);
        e = '0;
        e.ep = 5'h01;
        pulse(e);
        repeat (20) @(posedge aclk);
        check(n_take, takes_exp);
        rd(12'h3FC, 8'h35, hic_pkg::RESP_OK);
        wr(12'h084, 8'h01);
        taken(14'h0008);
        // frozen controller ignores a return
        ce <= 1'b0;
        ins(3'h1);
        repeat (3) @(posedge aclk);
        check({31'h0, core_out.gie}, 32'h0);
        ce <= 1'b1;
        // timers off before the suspend bit is written
        wr(12'h080, 8'h69);
        wr(12'h3FC, 8'h39);
        rd(12'h080, 8'h69, hic_pkg::RESP_OK);
        rd(12'h3FC, 8'h39, hic_pkg::RESP_OK);
        tally_and_finish();
    end
endmodule : tb
